// ==== pkg/mfs_pkg.sv ====
// ---------------------------------------------------------------
// Mode supervisor constants
// ---------------------------------------------------------------
package mfs_pkg;
    localparam int unsigned clk_hz = 25000000;
    localparam int unsigned wdto_ms = 310;
    localparam int unsigned in_idle_ms = 250;
    localparam int unsigned wdto_cycles_def = (clk_hz / 1000) * wdto_ms;
    localparam int unsigned in_idle_cycles_def = (clk_hz / 1000) * in_idle_ms;
    localparam int cnt_width = 24;
    localparam int word_width = 16;
    localparam int tog_pos = 15;
    localparam int on_bit_pos = 8;

    // Fault vector layout per channel
    localparam int f_overcur = 0;
    localparam int f_short = 1;
    localparam int f_overtemp = 2;
    localparam int f_os = 3;
    localparam int f_oloff = 4;
    localparam int f_olon = 5;
    localparam int f_width = 6;

    // Global fault bits
    localparam int g_undervolt = 0;
    localparam int g_overvolt = 1;
    localparam int g_clk = 2;
    localparam int g_width = 3;

    localparam logic [f_width-1:0] latchable_mask = 6'h07;
    localparam logic [f_width-1:0] keep_on_mask = 6'h38;
    localparam logic [f_width-1:0] ch_fault_reset = 6'h00;
    localparam logic [g_width-1:0] glob_fault_reset = 3'h0;

    typedef enum logic [3:0] {
        mfs_sleep = 4'h1,
        mfs_normal = 4'h2,
        mfs_failsafe = 4'h4,
        mfs_fault = 4'h8
    } mfs_mode_type;
endpackage : mfs_pkg

// ==== rtl/mfs_supervisor.sv ====
`timescale 1ns/100ps
module mfs_supervisor #(
    parameter int unsigned wdto_cycles = mfs_pkg::wdto_cycles_def,
    parameter int unsigned in_idle_cycles = mfs_pkg::in_idle_cycles_def
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    input wire logic spi_clk_in,
    input wire logic spi_rst_n_in,
    input wire logic active_low_reset_input_in,
    input wire logic [1:0] direct_in_in,
    input wire logic spi_word_valid_in,
    input wire logic [15:0] spi_word_in,
    input wire logic logic_supply_ok_in,
    input wire logic supply_loss_en_in,
    input wire logic watchdog_disable_bit_in,
    input wire logic overvoltage_en_in,
    input wire logic [1:0] direct_input_disable_in,
    input wire logic [1:0] on_bit_in,
    input wire logic [5:0] ch0_fault_cause_in,
    input wire logic [5:0] ch1_fault_cause_in,
    input wire logic [5:0] fault_enable_in,
    input wire logic [2:0] glob_fault_cause_in,
    input wire logic [1:0] retry_expired_in,
    input wire logic [1:0] retry_turn_on_in,
    input wire logic [1:0] retry_counter_reset_in,
    input wire logic power_on_event_in,
    input wire logic [1:0] fault_reg_read_in,
    input wire logic status_reg_read_in,
    output logic [3:0] mode_out,
    output logic failsafe_output_pin_out,
    output logic fault_status_pin_out,
    output logic [1:0] channel_enable_out,
    output logic [1:0] direct_only_out,
    output logic reg_reset_out,
    output logic reg_access_en_out,
    output logic [5:0] ch0_fault_bits_out,
    output logic [5:0] ch1_fault_bits_out,
    output logic [2:0] glob_fault_bits_out,
    output logic [1:0] latched_out,
    output logic [1:0] fault_control_signal_out
);
    // ---------------------------------------------------------------
    // Link side: watch toggle bit of each received word
    // ---------------------------------------------------------------
    logic link_tog;
    logic link_one_tog;
    logic link_bit;
    logic link_have;

    always_ff @(posedge spi_clk_in)
    begin
        if (!spi_rst_n_in)
        begin
            link_tog <= 1'b0;
            link_one_tog <= 1'b0;
            link_bit <= 1'b0;
            link_have <= 1'b0;
        end
        else if (spi_word_valid_in)
        begin
            // Toggle event on bit change, second toggle tracks a one
            link_have <= 1'b1;
            link_bit <= spi_word_in[mfs_pkg::tog_pos];
            if (link_have && spi_word_in[mfs_pkg::tog_pos] != link_bit)
                link_tog <= ~link_tog;
            link_one_tog <= link_one_tog ^ spi_word_in[mfs_pkg::tog_pos];
        end
    end

    // Word-arrival toggle for exit sequence
    logic link_word_tog;
    always_ff @(posedge spi_clk_in)
    begin
        if (!spi_rst_n_in)
            link_word_tog <= 1'b0;
        else if (spi_word_valid_in)
            link_word_tog <= ~link_word_tog;
    end

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    logic [2:0] s_rst;
    logic [2:0] s_in0;
    logic [2:0] s_in1;
    logic [2:0] s_tog;
    logic [2:0] s_one;
    logic [2:0] s_word;
    logic [2:0] s_vdd;
    logic rst_q;
    logic in0_q;
    logic in1_q;
    logic tog_q;
    logic one_q;
    logic word_q;
    logic vdd_q;

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            s_rst <= 3'h0;
            s_in0 <= 3'h0;
            s_in1 <= 3'h0;
            s_tog <= 3'h0;
            s_one <= 3'h0;
            s_word <= 3'h0;
            s_vdd <= 3'h0;
        end
        else if (clk_en_in)
        begin
            s_rst <= {s_rst[1:0], active_low_reset_input_in};
            s_in0 <= {s_in0[1:0], direct_in_in[0]};
            s_in1 <= {s_in1[1:0], direct_in_in[1]};
            s_tog <= {s_tog[1:0], link_tog};
            s_one <= {s_one[1:0], link_one_tog};
            s_word <= {s_word[1:0], link_word_tog};
            s_vdd <= {s_vdd[1:0], logic_supply_ok_in};
        end
    end

    // Accepted levels update only when stages two and three agree
    logic [1:0] pin_prev;
    logic tog_prev;
    logic one_prev;
    logic word_prev;
    logic vdd_seen;

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            rst_q <= 1'b0;
            in0_q <= 1'b0;
            in1_q <= 1'b0;
            tog_q <= 1'b0;
            one_q <= 1'b0;
            word_q <= 1'b0;
            vdd_q <= 1'b0;
        end
        else if (clk_en_in)
        begin
            if (s_rst[1] == s_rst[2]) rst_q <= s_rst[2];
            if (s_in0[1] == s_in0[2]) in0_q <= s_in0[2];
            if (s_in1[1] == s_in1[2]) in1_q <= s_in1[2];
            if (s_tog[1] == s_tog[2]) tog_q <= s_tog[2];
            if (s_one[1] == s_one[2]) one_q <= s_one[2];
            if (s_word[1] == s_word[2]) word_q <= s_word[2];
            if (s_vdd[1] == s_vdd[2]) vdd_q <= s_vdd[2];
        end
    end

    // ---------------------------------------------------------------
    // Input activity flags
    // ---------------------------------------------------------------
    localparam int cnt_w = mfs_pkg::cnt_width;
    logic [cnt_w-1:0] idle_cnt [2];
    logic [1:0] in_act;
    wire [1:0] pin_now = {in1_q, in0_q};
    localparam logic [23:0] idle_lim = 24'(in_idle_cycles);

    generate
        for (genvar c = 0; c < 2; c++)
        begin : g_act
            always_ff @(posedge clk_in)
            begin
                if (!reset_n_in)
                begin
                    idle_cnt[c] <= '0;
                    in_act[c] <= 1'b0;
                    pin_prev[c] <= 1'b0;
                end
                else if (clk_en_in)
                begin
                    pin_prev[c] <= pin_now[c];
                    // Any high level or edge restarts the idle count
                    if (pin_now[c] || pin_now[c] != pin_prev[c])
                    begin
                        idle_cnt[c] <= '0;
                        in_act[c] <= 1'b1;
                    end
                    else if (idle_cnt[c] >= idle_lim)
                        in_act[c] <= 1'b0;
                    else
                        idle_cnt[c] <= idle_cnt[c] + 24'h000001;
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // Mode conditions
    // ---------------------------------------------------------------
    wire wake_up = rst_q | in_act[0] | in_act[1];
    logic rst_prev;
    wire rst_rise = rst_q & ~rst_prev;
    wire wd_on = vdd_q & ~watchdog_disable_bit_in & rst_q;
    wire tog_evt = tog_q ^ tog_prev;
    wire one_evt = one_q ^ one_prev;
    wire word_evt = word_q ^ word_prev;
    logic [cnt_w-1:0] wd_cnt;
    localparam logic [23:0] wd_lim = 24'(wdto_cycles);
    wire wd_expire = wd_on && (wd_cnt >= wd_lim);
    wire vdd_fail = vdd_seen & ~vdd_q & supply_loss_en_in;

    wire [5:0] f0 = ch0_fault_cause_in & fault_enable_in;
    wire [5:0] f1 = ch1_fault_cause_in & fault_enable_in;
    wire ovr_q = glob_fault_cause_in[mfs_pkg::g_overvolt]
                 & overvoltage_en_in;
    wire udr_q = glob_fault_cause_in[mfs_pkg::g_undervolt];
    wire clk_q = glob_fault_cause_in[mfs_pkg::g_clk];
    wire fault_now = (|f0) | (|f1) | udr_q | ovr_q | clk_q;

    mfs_pkg::mfs_mode_type mode;
    mfs_pkg::mfs_mode_type next_mode;
    logic fs_flag;
    logic next_fs_flag;
    logic exit_armed;
    logic exit_cnt_run;

    always_comb
    begin
        next_fs_flag = fs_flag;
        if (wd_expire || vdd_fail)
            next_fs_flag = 1'b1;
        // Any second word inside the armed window releases, whatever its toggle bit
        else if (fs_flag && exit_armed && word_evt)
            next_fs_flag = 1'b0;
        if (!wake_up)
            next_mode = mfs_pkg::mfs_sleep;
        else if (fault_now)
            next_mode = mfs_pkg::mfs_fault;
        else if (next_fs_flag)
            next_mode = mfs_pkg::mfs_failsafe;
        else
            next_mode = mfs_pkg::mfs_normal;
    end

    wire fs_enter = next_fs_flag & ~fs_flag;
    wire fs_leave = fs_flag & ~next_fs_flag;

    // ---------------------------------------------------------------
    // Watchdog and fail-safe exit tracking
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            wd_cnt <= '0;
            rst_prev <= 1'b0;
            tog_prev <= 1'b0;
            one_prev <= 1'b0;
            word_prev <= 1'b0;
            vdd_seen <= 1'b0;
            fs_flag <= 1'b0;
            mode <= mfs_pkg::mfs_sleep;
            exit_armed <= 1'b0;
            exit_cnt_run <= 1'b0;
        end
        else if (clk_en_in)
        begin
            rst_prev <= rst_q;
            tog_prev <= tog_q;
            one_prev <= one_q;
            word_prev <= word_q;
            vdd_seen <= vdd_seen | vdd_q;
            fs_flag <= wake_up ? next_fs_flag : 1'b0;
            mode <= next_mode;
            // Timer restarts on reset rise or toggle
            // Armed exit window reuses the timer
            if (rst_rise || tog_evt || !wd_on || (fs_flag && !exit_armed))
                wd_cnt <= '0;
            else if (!wd_expire)
                wd_cnt <= wd_cnt + 24'h000001;
            // Exit: word with toggle bit one arms, next word releases
            if (!fs_flag || fs_leave)
                exit_armed <= 1'b0;
            else if (word_evt && one_evt)
                exit_armed <= 1'b1;
            else if (exit_armed && exit_cnt_run && wd_cnt >= wd_lim)
                exit_armed <= 1'b0;
            exit_cnt_run <= exit_armed;
        end
    end

    // ---------------------------------------------------------------
    // Per-channel latch, sticky bits, control signal
    // ---------------------------------------------------------------
    logic [5:0] sticky [2];
    logic [1:0] ctl_prev;
    logic [1:0] dl_low;
    logic [1:0] dl_pend;
    logic [1:0] ton_seen;
    wire [5:0] fcause [2] = '{f0, f1};
    wire in_fs = fs_flag;

    generate
        for (genvar c = 0; c < 2; c++)
        begin : g_ch
            wire ctl = (in_act[c] & ~direct_input_disable_in[c])
                       | (on_bit_in[c] & ~in_fs);
            assign fault_control_signal_out[c] = ctl;
            wire lat_cause = |(fcause[c] & mfs_pkg::latchable_mask);
            // Falling then rising control edge arms the delatch
            wire dl_seq = dl_low[c] & ctl & ~ctl_prev[c];
            wire dl_any = (dl_seq | retry_counter_reset_in[c]) & ~lat_cause;
            // Request waits for the turn-on edge to take effect
            wire dl_fire = (dl_any | dl_pend[c]) & retry_turn_on_in[c];
            // Latchable bits hold until a retry turn-on was seen
            wire [5:0] hold_lat = ton_seen[c] ? 6'h00
                                  : mfs_pkg::latchable_mask;
            wire read_c = fault_reg_read_in[c];
            always_ff @(posedge clk_in)
            begin
                if (!reset_n_in)
                begin
                    sticky[c] <= mfs_pkg::ch_fault_reset;
                    latched_out[c] <= 1'b0;
                    ctl_prev[c] <= 1'b0;
                    dl_low[c] <= 1'b0;
                    dl_pend[c] <= 1'b0;
                    ton_seen[c] <= 1'b1;
                end
                else if (clk_en_in)
                begin
                    ctl_prev[c] <= ctl;
                    if (!ctl && ctl_prev[c])
                        dl_low[c] <= 1'b1;
                    else if (dl_seq)
                        dl_low[c] <= 1'b0;
                    if (power_on_event_in || dl_fire)
                        dl_pend[c] <= 1'b0;
                    else if (dl_any)
                        dl_pend[c] <= 1'b1;
                    if (lat_cause)
                        ton_seen[c] <= 1'b0;
                    else if (retry_turn_on_in[c])
                        ton_seen[c] <= 1'b1;
                    if (power_on_event_in || fs_enter)
                        latched_out[c] <= 1'b0;
                    else if (lat_cause && retry_expired_in[c]
                             && retry_turn_on_in[c])
                        latched_out[c] <= 1'b1;
                    else if (dl_fire)
                        latched_out[c] <= 1'b0;
                    // Set wins over read clear
                    if (power_on_event_in)
                        sticky[c] <= mfs_pkg::ch_fault_reset;
                    else if (fs_enter || (fs_leave && !latched_out[c]))
                        sticky[c] <= fcause[c];
                    else if (dl_fire && latched_out[c])
                        sticky[c] <= fcause[c];
                    else if (read_c && !latched_out[c])
                        sticky[c] <= fcause[c]
                                     | (sticky[c] & hold_lat);
                    else
                        sticky[c] <= sticky[c] | fcause[c];
                end
            end
            // Keep-on faults leave the channel driven
            assign channel_enable_out[c] = (mode != mfs_pkg::mfs_sleep)
                & ~latched_out[c] & ~udr_q & ~ovr_q
                & ~(|(fcause[c] & ~mfs_pkg::keep_on_mask))
                & (dl_seq | ctl | in_act[c]);
        end
    endgenerate

    logic [2:0] gsticky;
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
            gsticky <= mfs_pkg::glob_fault_reset;
        else if (clk_en_in)
        begin
            if (power_on_event_in || fs_enter)
                gsticky <= {clk_q, ovr_q, udr_q};
            else if (status_reg_read_in)
                gsticky <= {clk_q, ovr_q, udr_q};
            else
                gsticky <= gsticky | {clk_q, ovr_q, udr_q};
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    logic fault_pin_q;
    logic safe_pin_q;
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            fault_pin_q <= 1'b1;
            safe_pin_q <= 1'b1;
        end
        else if (clk_en_in)
        begin
            fault_pin_q <= ~(fault_now | (|latched_out));
            safe_pin_q <= ~next_fs_flag | ~wake_up;
        end
    end

    assign mode_out = mode;
    assign failsafe_output_pin_out = safe_pin_q;
    assign fault_status_pin_out = fault_pin_q;
    assign direct_only_out = {2{fs_flag | ~rst_q}};
    assign reg_reset_out = fs_flag | (mode == mfs_pkg::mfs_sleep)
                           | fs_leave;
    assign reg_access_en_out = ~fs_flag & (mode != mfs_pkg::mfs_sleep);
    assign ch0_fault_bits_out = sticky[0];
    assign ch1_fault_bits_out = sticky[1];
    assign glob_fault_bits_out = gsticky;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_sleep_mode: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        clk_en_in && !wake_up |=> mode == mfs_pkg::mfs_sleep)
        else $error("no sleep without wake-up");
    a_fault_prio: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        clk_en_in && wake_up && fault_now |=> mode == mfs_pkg::mfs_fault)
        else $error("fault not prioritised");
    a_wd_entry: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        clk_en_in && wake_up && wd_expire |=> fs_flag)
        else $error("timeout missed fail-safe");
    a_wd_disable: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        clk_en_in && watchdog_disable_bit_in && !vdd_fail && !fs_flag
        |=> !fs_flag)
        else $error("disabled watchdog entered fail-safe");
    a_fspin_low: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        clk_en_in && wake_up && next_fs_flag |=> !safe_pin_q)
        else $error("fail-safe pin not low");
    a_fault_pin: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        clk_en_in && fault_now |=> !fault_pin_q)
        else $error("fault pin not low");
    a_latched_pin: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        |latched_out |=> !fault_pin_q)
        else $error("latched but pin high");
    a_sticky_hold: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        clk_en_in && !power_on_event_in && !fs_enter && !fs_leave
        && !fault_reg_read_in[0] && !(g_ch[0].dl_fire && latched_out[0])
        |=> (sticky[0] & $past(sticky[0])) == $past(sticky[0]))
        else $error("sticky bit lost without read");
    a_fs_access: assert property (
        @(posedge clk_in) disable iff (!reset_n_in)
        fs_flag |-> !reg_access_en_out && reg_reset_out)
        else $error("access open in fail-safe");
    c_to_fs: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        !fs_flag ##1 fs_flag);
    c_fs_exit: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        fs_flag ##1 !fs_flag && wake_up);
    c_latch: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        latched_out[0] ##1 !latched_out[0]);
endmodule : mfs_supervisor

// ==== tb/mfs_host_model.sv ====
`timescale 1ns/100ps
module mfs_host_model (
    output logic spi_clk_out,
    output logic spi_rst_n_out,
    output logic spi_word_valid_out,
    output logic [15:0] spi_word_out
);
    // -------------------------------------
    // Link clock stands still between words
    // -------------------------------------
    logic run = 1'b1;
    initial
    begin
        spi_clk_out = 1'b0;
        spi_rst_n_out = 1'b0;
        spi_word_valid_out = 1'b0;
        spi_word_out = 16'h0000;
        repeat (4) @(posedge spi_clk_out);
        spi_rst_n_out <= 1'b1;
        @(posedge spi_clk_out);
        run = 1'b0;
    end
    always #7.5 spi_clk_out = run ? ~spi_clk_out : spi_clk_out;
    task automatic send_word(input logic [15:0] w);
        run = 1'b1;
        repeat (2) @(posedge spi_clk_out);
        spi_word_valid_out <= 1'b1;
        spi_word_out <= w;
        @(posedge spi_clk_out);
        spi_word_valid_out <= 1'b0;
        // Released bus must not show a stale word
        spi_word_out <= ~w;
        repeat (3) @(posedge spi_clk_out);
        run = 1'b0;
    endtask : send_word
endmodule : mfs_host_model

// ==== tb/mfs_supervisor_tb.sv ====
`timescale 1ns/100ps
module mfs_supervisor_tb;
    // -------------------------------------
    // Shortened counts keep the run small
    // -------------------------------------
    localparam int unsigned wd_cyc = 200;
    localparam int unsigned idle_cyc = 100;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic rst_pin = 1'b0, sup_ok = 1'b1, loss_en = 1'b0;
    logic wdog_off = 1'b0, ovr_en = 1'b0, st_rd = 1'b0;
    logic [1:0] din = 2'h0, dis = 2'h0, onb = 2'h0, rexp = 2'h0;
    logic [1:0] rton = 2'h0, rcr = 2'h0, frd = 2'h0;
    logic [5:0] c0 = 6'h00, c1 = 6'h00;
    logic [2:0] gc = 3'h0;
    logic sclk, srst_n, sv, fso_n, fs_n, rr, ra;
    logic [15:0] sw;
    logic [3:0] mode;
    logic [1:0] ce, dof, lat, ctl;
    logic [5:0] fb0, fb1;
    logic [2:0] gb;
    int bad_count = 0;
    int checks_done = 0;
    int b;
    always #20 clk_in = ~clk_in;
    mfs_host_model u_mfs_host_model (.spi_clk_out(sclk),
        .spi_rst_n_out(srst_n), .spi_word_valid_out(sv),
        .spi_word_out(sw));
    mfs_supervisor #(.wdto_cycles(wd_cyc), .in_idle_cycles(idle_cyc))
    u_mfs_supervisor (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .clk_en_in(1'b1), .spi_clk_in(sclk), .spi_rst_n_in(srst_n),
        .active_low_reset_input_in(rst_pin), .direct_in_in(din),
        .spi_word_valid_in(sv), .spi_word_in(sw),
        .logic_supply_ok_in(sup_ok), .supply_loss_en_in(loss_en),
        .watchdog_disable_bit_in(wdog_off), .overvoltage_en_in(ovr_en),
        .direct_input_disable_in(dis), .on_bit_in(onb),
        .ch0_fault_cause_in(c0), .ch1_fault_cause_in(c1),
        .fault_enable_in(6'h07), .glob_fault_cause_in(gc),
        .retry_expired_in(rexp), .retry_turn_on_in(rton),
        .retry_counter_reset_in(rcr), .power_on_event_in(1'b0),
        .fault_reg_read_in(frd), .status_reg_read_in(st_rd),
        .mode_out(mode), .failsafe_output_pin_out(fso_n),
        .fault_status_pin_out(fs_n), .channel_enable_out(ce),
        .direct_only_out(dof), .reg_reset_out(rr),
        .reg_access_en_out(ra), .ch0_fault_bits_out(fb0),
        .ch1_fault_bits_out(fb1), .glob_fault_bits_out(gb),
        .latched_out(lat), .fault_control_signal_out(ctl));
    function automatic logic [1:0] exp_ctl(input logic [1:0] a,
        input logic [1:0] d, input logic [1:0] o);
        return (a & ~d) | o;
    endfunction : exp_ctl
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string n, input logic [5:0] e,
        input logic [5:0] g);
        checks_done++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Outputs are read before the edge's own updates land
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask : tick
    task automatic wait_mode(input logic [3:0] e, input int lim);
        int i;
        for (i = 0; i < lim && mode !== e; i++)
            @(posedge clk_in);
        if (mode !== e)
        begin
            bad_count++;
            $display("[FAIL] mode expected %h seen %h", e, mode);
            tally_and_finish();
        end
        else
            chk("mode", {2'h0, e}, {2'h0, mode});
    endtask : wait_mode
    task automatic leave_fs;
        u_mfs_host_model.send_word(16'h8000 | 16'($urandom));
        tick(8);
        chk("armed", 6'h04, {2'h0, mode});
        u_mfs_host_model.send_word(16'h7fff & 16'($urandom));
        wait_mode(4'h2, 30);
        chk("back", 6'h05, {3'h0, fso_n, rr, ra});
    endtask : leave_fs
    initial
    begin
        void'($urandom(91899));
        tick(12);
        chk("reset mode", 6'h01, {2'h0, mode});
        reset_n_in <= 1'b1;
        tick(6);
        chk("sleep pins", 6'h03, {2'h0, ce, fso_n, fs_n});
        rst_pin <= 1'b1;
        wait_mode(4'h2, 30);
        for (int k = 0; k < 4; k++)
        begin
            u_mfs_host_model.send_word({k[0], 15'($urandom)});
            tick(wd_cyc / 2);
        end
        chk("fed", 6'h02, {2'h0, mode});
        wait_mode(4'h4, wd_cyc);
        chk("fs pins", 6'h0b, {1'h0, fso_n, rr, ra, dof});
        // Second word after the window must not release
        u_mfs_host_model.send_word(16'h8000 | 16'($urandom));
        tick(wd_cyc + 20);
        u_mfs_host_model.send_word(16'h7fff & 16'($urandom));
        tick(8);
        chk("late word", 6'h04, {2'h0, mode});
        leave_fs();
        wdog_off <= 1'b1;
        tick(wd_cyc * 2);
        chk("wd off", 6'h02, {2'h0, mode});
        loss_en <= 1'b1;
        tick(2);
        sup_ok <= 1'b0;
        wait_mode(4'h4, 30);
        sup_ok <= 1'b1;
        loss_en <= 1'b0;
        tick(4);
        leave_fs();
        onb <= 2'h3;
        b = $urandom_range(2);
        c0 <= 6'h01 << b;
        tick(8);
        chk("fault mode", 6'h08, {2'h0, mode});
        chk("fault ch0", 6'h00, {4'h0, ce[0], fs_n});
        chk("bit ch0", 6'h01 << b, fb0);
        c0 <= 6'h00;
        tick(8);
        chk("pin freed", 6'h05, {1'h0, mode, fs_n});
        frd <= 2'h1;
        tick(1);
        frd <= 2'h0;
        tick(3);
        chk("read early", 6'h01 << b, fb0);
        rton <= 2'h1;
        tick(1);
        rton <= 2'h0;
        frd <= 2'h1;
        tick(1);
        frd <= 2'h0;
        tick(3);
        chk("read clear", 6'h00, fb0);
        gc <= 3'h2;
        tick(8);
        chk("over masked", 6'h02, {2'h0, mode});
        ovr_en <= 1'b1;
        tick(8);
        chk("over fault", 6'h08, {2'h0, mode});
        gc <= 3'h0;
        tick(8);
        chk("over bit", 6'h02, {3'h0, gb});
        st_rd <= 1'b1;
        tick(1);
        st_rd <= 1'b0;
        tick(3);
        chk("over read", 6'h00, {3'h0, gb});
        c1 <= 6'h01;
        rexp <= 2'h2;
        tick(8);
        rton <= 2'h2;
        tick(1);
        rton <= 2'h0;
        tick(6);
        chk("latch", 6'h04, {3'h0, lat, fs_n});
        c1 <= 6'h00;
        tick(8);
        frd <= 2'h2;
        tick(1);
        frd <= 2'h0;
        tick(3);
        chk("latched bit", 6'h01, fb1);
        chk("latched pin", 6'h00, {5'h0, fs_n});
        rcr <= 2'h2;
        tick(1);
        rcr <= 2'h0;
        rton <= 2'h2;
        tick(1);
        rton <= 2'h0;
        rexp <= 2'h0;
        tick(6);
        chk("delatch", 6'h01, {3'h0, lat, fs_n});
        chk("delatch bit", 6'h00, fb1);
        for (int k = 0; k < 4; k++)
        begin
            dis <= 2'($urandom);
            onb <= 2'($urandom);
            din <= 2'h3;
            tick(10);
            chk("ctl on", {4'h0, exp_ctl(2'h3, dis, onb)}, {4'h0, ctl});
        end
        din <= 2'h0;
        rst_pin <= 1'b0;
        tick(idle_cyc - 20);
        chk("not idle", 6'h02, {2'h0, mode});
        wait_mode(4'h1, 60);
        chk("sleep off", 6'h00, {4'h0, ce});
        chk("ctl idle", {4'h0, exp_ctl(2'h0, dis, onb)}, {4'h0, ctl});
        tally_and_finish();
    end
endmodule : mfs_supervisor_tb
